// >>> design/t2co_top.sv
// Purpose: sixteen-bit reloadable timer with 50% clock output
// Assumes: APB slave, zero wait states, pins synchronous to clk
// Notes: one internal tick every two clocks
// Functional notes
// - clock-out toggles pin on each overflow
// - low byte counts at half clock rate
// - overflow copies reload pair into count outside capture
// - no interrupt from overflows in clock-out
// - out period four times wrap distance
// - drive clock pin when output enabled
// - run bit starts and stops counting
// - baud and clock-out share reload pair
// - overflow flag only without serial selects
// - enabled trigger fall sets external flag outside updown
// - external flag no request in updown
// - selects route overflow to serial clocks
// - source select picks clock or pin
`timescale 1ns/10ps
module t2co_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [t2co_pkg::T2CO_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic clock_io_in,
	output logic clock_io_out,
	output logic clock_io_oe_n,
	input wire logic external_trigger_pin,
	// serial port clocks
	input wire logic timer1_ovf,
	output logic rx_baud_tick,
	output logic tx_baud_tick,
	// interrupt request to the cpu
	output logic timer_irq
);
	import t2co_pkg::*;

	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [7:0] ctrl_r;
	logic [1:0] mode_r;
	logic [15:0] cnt_r;
	logic [15:0] rld_r;
	logic clk_out_r;
	logic oe_n_r;
	logic rx_r;
	logic tx_r;
	logic irq_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic setup;
	logic wr_en;
	logic hit;
	logic [31:0] rd_nxt;
	logic [7:0] wb;
	t2co_mode_t mode;
	logic baud;
	logic clkout_mode;
	logic up;
	logic ovf_evt;
	logic unf_evt;
	logic trig;
	logic [7:0] ctrl_nxt;

	t2co_evt_if evt ();

	// release reset through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	assign evt.pin_lvl[T2CO_PIN_CLK] = clock_io_in;
	assign evt.pin_lvl[T2CO_PIN_TRG] = external_trigger_pin;
	assign evt.src_ext = ctrl_r[T2CO_B_SRC];
	assign evt.run = ctrl_r[T2CO_B_RUN];

	t2co_edge u_edge (
		.clk(clk),
		.rst_n(rst_n),
		.evt(evt.edge_mp)
	);

	t2co_tick u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.evt(evt.tick_mp)
	);

	// apb decode; access phase always lasts one cycle
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready_r;
	assign wb = pwdata[7:0];

	always_comb begin
		hit = 1'b1;
		rd_nxt = 32'h0000_0000;
		case (paddr)
			T2CO_OFS_CTRL: rd_nxt[7:0] = ctrl_r;
			T2CO_OFS_MODE: rd_nxt[1:0] = mode_r;
			T2CO_OFS_CNT_LO: rd_nxt[7:0] = cnt_r[7:0];
			T2CO_OFS_CNT_HI: rd_nxt[7:0] = cnt_r[15:8];
			T2CO_OFS_RLD_LO: rd_nxt[7:0] = rld_r[7:0];
			T2CO_OFS_RLD_HI: rd_nxt[7:0] = rld_r[15:8];
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup & ~hit;
			if (setup && !pwrite) begin
				prdata_r <= rd_nxt;
			end
		end
	end

	// operating mode; serial selects override capture/reload select
	assign baud = ctrl_r[T2CO_B_RXSEL] | ctrl_r[T2CO_B_TXSEL];
	always_comb begin
		case ({mode_r[T2CO_B_UPDN], baud, ctrl_r[T2CO_B_CPRL]})
			3'b000: mode = T2CO_M_RELOAD;
			3'b001: mode = T2CO_M_CAPTURE;
			3'b010, 3'b011, 3'b110, 3'b111: mode = T2CO_M_BAUD;
			3'b100, 3'b101: mode = T2CO_M_UPDOWN;
			default: mode = T2CO_M_RELOAD;
		endcase
	end

	assign clkout_mode = mode_r[T2CO_B_OE] & ~ctrl_r[T2CO_B_SRC];
	// trigger pin sets direction only in updown mode
	assign up = (mode != T2CO_M_UPDOWN) | external_trigger_pin;
	assign ovf_evt = evt.tick & up & (cnt_r == T2CO_CNT_MAX);
	assign unf_evt = evt.tick & ~up & (cnt_r == rld_r);
	assign trig = evt.pin_fall[T2CO_PIN_TRG] & ctrl_r[T2CO_B_EXEN] &
		(mode != T2CO_M_UPDOWN);

	// counter; a software write beats the hardware update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= T2CO_CNT_RST;
		end else if (wr_en && paddr == T2CO_OFS_CNT_LO) begin
			cnt_r[7:0] <= wb;
		end else if (wr_en && paddr == T2CO_OFS_CNT_HI) begin
			cnt_r[15:8] <= wb;
		end else if (ovf_evt && mode != T2CO_M_CAPTURE) begin
			cnt_r <= rld_r;
		end else if (unf_evt) begin
			cnt_r <= T2CO_CNT_MAX;
		end else if (trig && mode == T2CO_M_RELOAD) begin
			cnt_r <= rld_r;
		end else if (evt.tick) begin
			cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
		end
	end

	// reload pair; capture takes the count on a trigger fall
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rld_r <= T2CO_RLD_RST;
		end else if (wr_en && paddr == T2CO_OFS_RLD_LO) begin
			rld_r[7:0] <= wb;
		end else if (wr_en && paddr == T2CO_OFS_RLD_HI) begin
			rld_r[15:8] <= wb;
		end else if (trig && mode == T2CO_M_CAPTURE) begin
			rld_r <= cnt_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= T2CO_MODE_RST;
		end else if (wr_en && paddr == T2CO_OFS_MODE) begin
			mode_r <= wb[1:0] & T2CO_MODE_MASK;
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_en && paddr == T2CO_OFS_CTRL) begin
			ctrl_nxt = wb;
		end
		if (ovf_evt && !baud && !clkout_mode) begin
			ctrl_nxt[T2CO_B_OVF] = 1'b1;
		end
		if (trig) begin
			ctrl_nxt[T2CO_B_EXT] = 1'b1;
		end else if (mode == T2CO_M_UPDOWN && (ovf_evt || unf_evt)) begin
			// acts as a seventeenth count bit
			ctrl_nxt[T2CO_B_EXT] = ~ctrl_r[T2CO_B_EXT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= T2CO_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// clock output; toggling per overflow gives 50% duty
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_out_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			if (ovf_evt && clkout_mode) begin
				clk_out_r <= ~clk_out_r;
			end
			oe_n_r <= ~mode_r[T2CO_B_OE];
		end
	end

	// serial clocks and interrupt request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_r <= 1'b0;
			tx_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			rx_r <= ctrl_r[T2CO_B_RXSEL] ? ovf_evt : timer1_ovf;
			tx_r <= ctrl_r[T2CO_B_TXSEL] ? ovf_evt : timer1_ovf;
			irq_r <= ctrl_r[T2CO_B_OVF] |
				(ctrl_r[T2CO_B_EXT] & ~mode_r[T2CO_B_UPDN]);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign clock_io_out = clk_out_r;
	assign clock_io_oe_n = oe_n_r;
	assign rx_baud_tick = rx_r;
	assign tx_baud_tick = tx_r;
	assign timer_irq = irq_r;

	// helper: cycles between overflows while setup is undisturbed
	logic [17:0] per_r;
	logic per_ok_r;
	logic any_wr;
	assign any_wr = wr_en;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_r <= 18'h00000;
			per_ok_r <= 1'b0;
		end else begin
			per_r <= ovf_evt ? 18'h00001 : per_r + 18'h00001;
			// a trigger reload cuts a period short, so it voids the check too
			if (any_wr || trig || !ctrl_r[T2CO_B_RUN] ||
					ctrl_r[T2CO_B_SRC]) begin
				per_ok_r <= 1'b0;
			end else if (ovf_evt) begin
				per_ok_r <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_clkout_toggle: assert property (
		ovf_evt && clkout_mode |=> clock_io_out != $past(clock_io_out))
		else $error("clock output did not toggle on overflow");
	chk_half_rate: assert property (
		evt.tick && !ctrl_r[T2CO_B_SRC] |=> !evt.tick)
		else $error("internal tick faster than half clock");
	chk_reload_copy: assert property (
		ovf_evt && mode != T2CO_M_CAPTURE && !wr_en |=>
		cnt_r == $past(rld_r))
		else $error("overflow did not copy reload pair");
	chk_clkout_noirq: assert property (
		clkout_mode && ovf_evt && !ctrl_r[T2CO_B_OVF] && !wr_en |=>
		!ctrl_r[T2CO_B_OVF])
		else $error("overflow flag set in clock-out mode");
	chk_out_period: assert property (
		ovf_evt && per_ok_r && clkout_mode && mode == T2CO_M_RELOAD |->
		per_r == 18'((T2CO_WRAP - {2'b00, rld_r}) << 1))
		else $error("clock-out period wrong");
	chk_pin_drive: assert property (
		mode_r[T2CO_B_OE] |=> !clock_io_oe_n)
		else $error("clock pin not driven");
	chk_run_stop: assert property (
		!ctrl_r[T2CO_B_RUN] && !wr_en && !trig |=> $stable(cnt_r))
		else $error("counter moved while stopped");
	chk_ovf_flag: assert property (
		ovf_evt && !baud && !clkout_mode |=> ctrl_r[T2CO_B_OVF])
		else $error("overflow flag not set");
	chk_ext_flag: assert property (
		trig |=> ctrl_r[T2CO_B_EXT])
		else $error("external flag not set on trigger");
	chk_updown_irq: assert property (
		mode_r[T2CO_B_UPDN] && !ctrl_r[T2CO_B_OVF] |=> !timer_irq)
		else $error("request raised by external flag in updown");
	chk_baud_route: assert property (
		ctrl_r[T2CO_B_TXSEL] |=> tx_baud_tick == $past(ovf_evt))
		else $error("transmit clock not routed from overflow");
	chk_src_pin: assert property (
		evt.tick && ctrl_r[T2CO_B_SRC] |-> evt.pin_fall[T2CO_PIN_CLK])
		else $error("external tick without pin fall");
	chk_baud_reload: assert property (
		ovf_evt && baud && !wr_en |=> cnt_r == $past(rld_r))
		else $error("serial mode did not auto reload");

	cov_clkout: cover property (ovf_evt && clkout_mode ##[1:1000] ovf_evt);
	cov_capture: cover property (trig && mode == T2CO_M_CAPTURE);
	cov_baud_clk: cover property (ovf_evt && baud && clkout_mode);
	cov_underflow: cover property (unf_evt);
endmodule

// >>> common/t2co_pkg.sv
// Purpose: constants and types shared by the timer-two clock-out block
// Assumes: 8-bit registers on 32-bit APB words, one clock domain
// Notes: register offsets are byte addresses
package t2co_pkg;
	localparam int T2CO_ADDR_W = 8;
	localparam logic [7:0] T2CO_OFS_CTRL = 8'hC8;
	localparam logic [7:0] T2CO_OFS_MODE = 8'hCC;
	localparam logic [7:0] T2CO_OFS_CNT_LO = 8'hD0;
	localparam logic [7:0] T2CO_OFS_CNT_HI = 8'hD4;
	localparam logic [7:0] T2CO_OFS_RLD_LO = 8'hD8;
	localparam logic [7:0] T2CO_OFS_RLD_HI = 8'hDC;
	// control register fields
	localparam int T2CO_B_OVF = 7;
	localparam int T2CO_B_EXT = 6;
	localparam int T2CO_B_RXSEL = 5;
	localparam int T2CO_B_TXSEL = 4;
	localparam int T2CO_B_EXEN = 3;
	localparam int T2CO_B_RUN = 2;
	localparam int T2CO_B_SRC = 1;
	localparam int T2CO_B_CPRL = 0;
	// mode register fields
	localparam int T2CO_B_OE = 1;
	localparam int T2CO_B_UPDN = 0;
	localparam logic [1:0] T2CO_MODE_MASK = 2'h3;
	// reset values
	localparam logic [7:0] T2CO_CTRL_RST = 8'h00;
	localparam logic [1:0] T2CO_MODE_RST = 2'h0;
	localparam logic [15:0] T2CO_CNT_RST = 16'h0000;
	localparam logic [15:0] T2CO_RLD_RST = 16'h0000;
	localparam logic [15:0] T2CO_CNT_MAX = 16'hFFFF;
	// internal count tick is the peripheral clock divided by this
	localparam int T2CO_PRESCALE = 2;
	localparam logic [17:0] T2CO_WRAP = 18'h10000;
	// pin indices on the edge carrier
	localparam int T2CO_PIN_CLK = 0;
	localparam int T2CO_PIN_TRG = 1;
	typedef enum logic [1:0] {
		T2CO_M_RELOAD = 2'b00,
		T2CO_M_CAPTURE = 2'b01,
		T2CO_M_BAUD = 2'b10,
		T2CO_M_UPDOWN = 2'b11
	} t2co_mode_t;
endpackage

// >>> common/t2co_evt_if.sv
// Purpose: carries pin levels, edges and the count tick between modules
// Assumes: single clock domain
// Notes: pin_fall is a one-cycle pulse
`timescale 1ns/10ps
interface t2co_evt_if;
	logic [1:0] pin_lvl;
	logic [1:0] pin_fall;
	logic src_ext;
	logic run;
	logic tick;
	modport edge_mp (input pin_lvl, output pin_fall);
	modport tick_mp (input pin_fall, input src_ext, input run, output tick);
	modport core_mp (output pin_lvl, output src_ext, output run,
		input pin_fall, input tick);
endinterface

// >>> design/t2co_edge.sv
// Purpose: falling-edge detection on the clock and trigger pins
// Assumes: pin levels already synchronous to clk
// Notes: first sample after reset assumes pins were high
`timescale 1ns/10ps
module t2co_edge (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// carrier
	t2co_evt_if.edge_mp evt
);
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_pin
			logic prev_r;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					prev_r <= 1'b1;
				end else begin
					prev_r <= evt.pin_lvl[i];
				end
			end
			assign evt.pin_fall[i] = prev_r & ~evt.pin_lvl[i];
		end
	endgenerate
endmodule

// >>> design/t2co_tick.sv
// Purpose: count tick source, internal half-rate or pin falling edge
// Assumes: run low holds the phase at zero
// Notes: first internal tick comes one cycle after run rises
`timescale 1ns/10ps
module t2co_tick (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// carrier
	t2co_evt_if.tick_mp evt
);
	import t2co_pkg::*;
	logic ph_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= 1'b0;
		end else begin
			ph_r <= evt.run & ~evt.src_ext & ~ph_r;
		end
	end
	assign evt.tick = evt.run &
		(evt.src_ext ? evt.pin_fall[T2CO_PIN_CLK] : ph_r);
endmodule

// >>> verif/t2co_pin_partner.sv
// Purpose: far-side logic sampling the timer clock pin on clk
// Assumes: pin level already resolved from all drivers
// Notes: reports the last completed high and low times in clocks
`timescale 1ns/10ps
module t2co_pin_partner (
	// clock
	input wire logic clk,
	// observed pin
	input wire logic pin,
	// measured lengths
	output int hi_len,
	output int lo_len
);
	int run_len;
	logic last;
	initial begin
		hi_len = 0;
		lo_len = 0;
		run_len = 0;
		last = 1'b1;
	end
	// the partial first segment is reported too, counted from the first clock edge
	always @(posedge clk) begin
		if (pin !== last) begin
			if (last)
				hi_len <= run_len;
			else
				lo_len <= run_len;
			run_len <= 1;
		end else begin
			run_len <= run_len + 1;
		end
		last <= pin;
	end
endmodule

// >>> verif/testbench.sv
// Purpose: self-checking bench for the timer-two clock-out block
// Assumes: zero wait state apb slave, pins synchronous to clk
// Notes: reload 16'hFFF0 gives a 32 clock half period
`timescale 1ns/10ps
module testbench;
	import t2co_pkg::*;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, held;
	logic err, ext_pin, trg, t1_ovf, out, oe_n, rx_t, tx_t, irq;
	wire logic pin = oe_n ? ext_pin : out;
	int num_errors, comparisons, cyc, hi_len, lo_len, n;
	t2co_top t2co_top_i (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_io_in(pin), .clock_io_out(out),
		.clock_io_oe_n(oe_n), .external_trigger_pin(trg),
		.timer1_ovf(t1_ovf), .rx_baud_tick(rx_t), .tx_baud_tick(tx_t),
		.timer_irq(irq));
	t2co_pin_partner t2co_pin_partner_i (.clk(clk), .pin(pin),
		.hi_len(hi_len), .lo_len(lo_len));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one apb transfer; holds the request until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr16(input logic [7:0] lo, input logic [15:0] v);
		apb(1'b1, lo, {24'h0, v[7:0]});
		apb(1'b1, lo + 8'h04, {24'h0, v[15:8]});
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk({31'h0, err}, 32'h0);
		chk(q, e);
	endtask
	task fall(input int k);
		repeat (k) begin
			@(posedge clk) ext_pin <= 1'b0;
			repeat (3) @(posedge clk);
			ext_pin <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, t1_ovf} = '0;
		{ext_pin, trg, arst_n} = 3'b110;
		{num_errors, comparisons, cyc} = '0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(T2CO_OFS_CTRL, 32'h00);
		rd(T2CO_OFS_MODE, 32'h00);
		apb(1'b0, 8'h00, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		// clock-out set up in the documented order
		apb(1'b1, T2CO_OFS_MODE, 32'h02);
		apb(1'b1, T2CO_OFS_CTRL, 32'h00);
		wr16(T2CO_OFS_RLD_LO, 16'hFFF0);
		wr16(T2CO_OFS_CNT_LO, 16'hFFF0);
		apb(1'b1, T2CO_OFS_CTRL, 32'h04);
		repeat (200) @(posedge clk);
		chk({31'h0, oe_n}, 32'h0);
		chk(hi_len, 32);
		chk(lo_len, 32);
		chk({31'h0, irq}, 32'h0);
		rd(T2CO_OFS_CTRL, 32'h04);
		// baud clock alongside clock-out, same reload pair
		apb(1'b1, T2CO_OFS_CTRL, 32'h14);
		@(posedge clk);
		n = 0;
		repeat (64) begin
			@(posedge clk);
			n += tx_t;
			chk({31'h0, rx_t}, 32'h0);
		end
		chk(n, 2);
		chk(hi_len, 32);
		@(posedge clk) t1_ovf <= 1'b1;
		@(posedge clk) t1_ovf <= 1'b0;
		#1 chk({31'h0, rx_t}, 32'h1);
		// stop holds the count
		apb(1'b1, T2CO_OFS_CTRL, 32'h00);
		apb(1'b0, T2CO_OFS_CNT_LO, 32'h0);
		held = q;
		repeat (20) @(posedge clk);
		rd(T2CO_OFS_CNT_LO, held);
		// plain reload timer sets the overflow flag
		apb(1'b1, T2CO_OFS_MODE, 32'h00);
		@(posedge clk);
		#1 chk({31'h0, oe_n}, 32'h1);
		wr16(T2CO_OFS_CNT_LO, 16'hFFF0);
		apb(1'b1, T2CO_OFS_CTRL, 32'h04);
		repeat (80) @(posedge clk);
		rd(T2CO_OFS_CTRL, 32'h84);
		chk({31'h0, irq}, 32'h1);
		// stop first: an overflow in the clear cycle would keep the flag set
		apb(1'b1, T2CO_OFS_CTRL, 32'h80);
		rd(T2CO_OFS_CTRL, 32'h80);
		apb(1'b1, T2CO_OFS_CTRL, 32'h00);
		rd(T2CO_OFS_CTRL, 32'h00);
		chk({31'h0, irq}, 32'h0);
		// trigger fall with enable sets the external flag
		apb(1'b1, T2CO_OFS_CTRL, 32'h08);
		@(posedge clk) trg <= 1'b0;
		repeat (4) @(posedge clk);
		rd(T2CO_OFS_CTRL, 32'h48);
		chk({31'h0, irq}, 32'h1);
		rd(T2CO_OFS_CNT_LO, 32'hF0);
		trg <= 1'b1;
		apb(1'b1, T2CO_OFS_CTRL, 32'h00);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// updown mode keeps the external flag from requesting
		apb(1'b1, T2CO_OFS_MODE, 32'h01);
		apb(1'b1, T2CO_OFS_CTRL, 32'h40);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(T2CO_OFS_CTRL, 32'h40);
		apb(1'b1, T2CO_OFS_MODE, 32'h00);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, T2CO_OFS_CTRL, 32'h00);
		// counter mode counts pin falls
		apb(1'b1, T2CO_OFS_CTRL, 32'h02);
		wr16(T2CO_OFS_CNT_LO, 16'h0000);
		apb(1'b1, T2CO_OFS_CTRL, 32'h06);
		fall(3);
		rd(T2CO_OFS_CNT_LO, 32'h03);
		rd(T2CO_OFS_CNT_HI, 32'h00);
		stop_test();
	end
endmodule
